// ---- core/ctw_core_timer.sv ----
`include "ctw_defs.svh"

module ctw_core_timer
    import ctw_pkg::*;
#(
    parameter int DLY_CYC = `CTW_DLY_RST_CYC,
    parameter int CNT_W   = 8
) (
    input  wire logic          core_clk_i,
    input  wire logic          resetn_i,
    input  wire logic          delayed_reset_pin_n_i,
    input  wire logic          ext_irq_i,
    input  ctw_pkg::ctw_addr_t addr_i,
    input  ctw_pkg::ctw_data_t wdata_i,
    input  wire logic          wr_i,
    input  wire logic          rd_i,
    output ctw_pkg::ctw_data_t rdata_o,
    output logic               timer_irq_o,
    output logic               wdog_reset_o,
    output logic               cpu_run_o,
    output logic               cpu_clk_en_o
);
    import ctw_pkg::*;

    typedef struct packed {
        logic             osc_ph;
        logic [1:0]       pre;
        logic [CNT_W-1:0] cnt;
        logic [1:0]       mid;
        logic [2:0]       per;
        logic             ovf;
        logic             perf;
        logic             ovie;
        logic             peie;
        logic [1:0]       rate;
        logic             wd_dis;
        logic             wd_rst;
        logic             wd_hold;
        logic             idle_st;
        logic             stop_st;
        ctw_pwr_e         pwr;
        logic             irq;
        ctw_data_t        rdata;
        logic             cpu_run;
        logic             clk_en;
    } ctw_top_s;

    ctw_top_s st;
    ctw_top_s next_st;
    logic     int_resetn;
    logic     dly_run;
    logic     wd_tick;
    logic     e_tick;
    logic     per_tick;

    // address match helper, used for every register decode
    function automatic logic hit(input ctw_addr_t a, input ctw_addr_t ref_a);
        hit = (a == ref_a);
    endfunction : hit

    // tap selection from rate field: bit k of the periodic divider
    function automatic logic tap_rise(input logic [2:0] old_v, input logic [2:0] new_v,
                                      input logic [1:0] rate);
        logic [3:0] o;
        logic [3:0] n;
        o = {old_v, 1'b1};
        n = {new_v, 1'b1};
        if (rate == 2'h0) begin
            tap_rise = 1'b1;
        end else begin
            tap_rise = n[rate] & ~o[rate] & (new_v[rate - 2'h1 +: 1] == 1'b1);
        end
    endfunction : tap_rise

    // watchdog timeout delayed one cycle resets the whole block
    assign int_resetn = resetn_i & ~st.wd_hold;

    // oscillator over two gives the peripheral enable
    assign e_tick = st.osc_ph & (st.pwr != CTW_STOP);

    // periodic output tick: selected tap completes a period
    always_comb begin
        per_tick = 1'b0;
        if (e_tick && st.pre == 2'(`CTW_PRE_DIV - 1) && st.cnt == '1 && st.mid == '1) begin
            case (st.rate)
                2'h0:    per_tick = 1'b1;
                2'h1:    per_tick = st.per[0];
                2'h2:    per_tick = &st.per[1:0];
                2'h3:    per_tick = &st.per[2:0];
                default: per_tick = 1'b0;
            endcase
        end
    end

    // watchdog divide-by-eight, cleared by service write
    ctw_divider #(
        .DIV (`CTW_WD_DIV)
    ) u_wd_div (
        .core_clk_i (core_clk_i),
        .resetn_i   (int_resetn),
        .sync_clr_i (wr_i && hit(addr_i, `CTW_ADDR_WDSVC) && wdata_i == `CTW_WDSVC_DATA),
        .tick_i     (per_tick),
        .tick_o     (wd_tick)
    );

    // delayed reset pin release count
    ctw_rst_delay #(
        .DLY_CYC (DLY_CYC)
    ) u_dly (
        .core_clk_i            (core_clk_i),
        .resetn_i              (int_resetn),
        .delayed_reset_pin_n_i (delayed_reset_pin_n_i),
        .tick_i                (st.pwr != CTW_STOP),
        .run_o                 (dly_run)
    );

    // next-state logic of the whole timer
    always_comb begin
        logic wrap;
        logic tcs_wr;
        logic ov_set;
        logic pe_set;
        wrap    = 1'b0;
        tcs_wr  = wr_i && hit(addr_i, `CTW_ADDR_TCS);
        ov_set  = 1'b0;
        pe_set  = per_tick;
        next_st = st;
        next_st.osc_ph = ~st.osc_ph;

        // prescaler and ripple chain, halted in stop
        if (e_tick) begin
            next_st.pre = st.pre + 2'h1;
            if (st.pre == 2'(`CTW_PRE_DIV - 1)) begin
                next_st.cnt = st.cnt + CNT_W'(1);
                wrap        = (st.cnt == '1);
                if (wrap) begin
                    next_st.mid = st.mid + 2'h1;
                    if (st.mid == '1) begin
                        next_st.per = st.per + 3'h1;
                    end
                end
            end
        end
        ov_set = wrap;

        // overflow flag: clear by one, set wins
        if (tcs_wr && wdata_i[`CTW_TCS_OVCLR]) begin
            next_st.ovf = 1'b0;
        end
        if (ov_set) begin
            next_st.ovf = 1'b1;
        end

        // periodic flag: clear by one, set wins
        if (tcs_wr && wdata_i[`CTW_TCS_PECLR]) begin
            next_st.perf = 1'b0;
        end
        if (pe_set) begin
            next_st.perf = 1'b1;
        end

        // writable control fields; flag positions ignored
        if (tcs_wr) begin
            next_st.ovie = wdata_i[`CTW_TCS_OVIE];
            next_st.peie = wdata_i[`CTW_TCS_PEIE];
            next_st.rate = wdata_i[`CTW_TCS_RATE_HI:`CTW_TCS_RATE_LO];
        end
        if (wr_i && hit(addr_i, `CTW_ADDR_WDC)) begin
            next_st.wd_dis = wdata_i[`CTW_WDC_DIS];
        end

        // watchdog timeout raises internal reset
        next_st.wd_rst  = wd_tick && !st.wd_dis;
        next_st.wd_hold = st.wd_rst;

        // combined interrupt request
        next_st.irq = (next_st.ovf && next_st.ovie) || (next_st.perf && next_st.peie);

        // power modes
        case (st.pwr)
            CTW_RUN: begin
                if (wr_i && hit(addr_i, `CTW_ADDR_PSR)) begin
                    if (wdata_i == `CTW_PSR_CMD_STOP) begin
                        next_st.pwr = CTW_STOP;
                    end else if (wdata_i == `CTW_PSR_CMD_IDLE) begin
                        next_st.pwr = CTW_IDLE;
                    end
                end
            end
            CTW_IDLE: begin
                if (st.irq || ext_irq_i) begin
                    next_st.pwr     = CTW_RUN;
                    next_st.idle_st = 1'b1;
                end
            end
            CTW_STOP: begin
                if (ext_irq_i || !delayed_reset_pin_n_i) begin
                    next_st.pwr     = CTW_RUN;
                    next_st.stop_st = 1'b1;
                end
            end
            default: next_st.pwr = CTW_RUN;
        endcase
        if (rd_i && hit(addr_i, `CTW_ADDR_PSR)) begin
            next_st.idle_st = 1'b0;
            next_st.stop_st = 1'b0;
        end

        // read data one cycle after the strobe; clear bits read zero
        next_st.rdata = '0;
        if (rd_i) begin
            if (hit(addr_i, `CTW_ADDR_TCS)) begin
                next_st.rdata = {st.ovf, st.perf, st.ovie, st.peie, 2'h0, st.rate};
            end else if (hit(addr_i, `CTW_ADDR_CNT)) begin
                next_st.rdata = ctw_data_t'(st.cnt);
            end else if (hit(addr_i, `CTW_ADDR_WDC)) begin
                next_st.rdata = {7'h0, st.wd_dis};
            end else if (hit(addr_i, `CTW_ADDR_PSR)) begin
                next_st.rdata = {6'h0, st.stop_st, st.idle_st};
            end
        end

        next_st.cpu_run = dly_run;
        next_st.clk_en  = (next_st.pwr == CTW_RUN) && dly_run;
    end

    // state register; reset values of all fields
    always_ff @(posedge core_clk_i or negedge int_resetn) begin
        if (!int_resetn) begin
            st        <= '0;
            st.cnt    <= CNT_W'(`CTW_CNT_RST);
            st.rate   <= `CTW_RATE_RST;
            st.wd_dis <= `CTW_WDDIS_RST;
            st.pwr    <= CTW_RUN;
        end else begin
            st <= next_st;
        end
    end

    assign rdata_o      = st.rdata;
    assign timer_irq_o  = st.irq;
    assign wdog_reset_o = st.wd_rst;
    assign cpu_run_o    = st.cpu_run;
    assign cpu_clk_en_o = st.clk_en;
endmodule : ctw_core_timer

// ---- inc/ctw_defs.svh ----
`ifndef CTW_DEFS_SVH
`define CTW_DEFS_SVH

// register offsets on the internal bus
`define CTW_ADDR_TCS      16'h0008
`define CTW_ADDR_CNT      16'h0009
`define CTW_ADDR_WDC      16'h000d
`define CTW_ADDR_PSR      16'h0018
`define CTW_ADDR_WDSVC    16'h3ff0

// timer control/status field positions
`define CTW_TCS_OVF       7
`define CTW_TCS_PER       6
`define CTW_TCS_OVIE      5
`define CTW_TCS_PEIE      4
`define CTW_TCS_OVCLR     3
`define CTW_TCS_PECLR     2
`define CTW_TCS_RATE_HI   1
`define CTW_TCS_RATE_LO   0

// watchdog control field position
`define CTW_WDC_DIS       0

// power save register fields and commands, watchdog service data
`define CTW_PSR_STOP      1
`define CTW_PSR_IDLE      0
`define CTW_PSR_CMD_STOP  8'h01
`define CTW_PSR_CMD_IDLE  8'h02
`define CTW_WDSVC_DATA    8'h00

// reset values
`define CTW_RATE_RST      2'h3
`define CTW_WDDIS_RST     1'h1
`define CTW_CNT_RST       8'h03

// timing
`define CTW_PRE_DIV       4
`define CTW_OSC_DIV       2
`define CTW_WD_DIV        8
`define CTW_DLY_RST_CYC   4064

`endif

// ---- inc/ctw_pkg.sv ----
package ctw_pkg;
    typedef logic [15:0] ctw_addr_t;
    typedef logic [7:0]  ctw_data_t;
    typedef enum logic [1:0] {
        CTW_RUN,
        CTW_IDLE,
        CTW_STOP
    } ctw_pwr_e;
endpackage : ctw_pkg

// ---- core/ctw_divider.sv ----
`include "ctw_defs.svh"

// free-running divider: one-cycle tick every DIV input ticks
module ctw_divider #(
    parameter int DIV = 2
) (
    input  wire logic core_clk_i,
    input  wire logic resetn_i,
    input  wire logic sync_clr_i,
    input  wire logic tick_i,
    output logic      tick_o
);
    localparam int W = (DIV > 1) ? $clog2(DIV) : 1;

    typedef struct packed {
        logic [W-1:0] cnt;
        logic         tick;
    } ctw_div_s;

    ctw_div_s st;
    ctw_div_s next_st;

    // count input ticks, pulse on wrap
    always_comb begin
        next_st      = st;
        next_st.tick = 1'b0;
        if (sync_clr_i) begin
            next_st.cnt = '0;
        end else if (tick_i) begin
            if (st.cnt == W'(DIV - 1)) begin
                next_st.cnt  = '0;
                next_st.tick = 1'b1;
            end else begin
                next_st.cnt = st.cnt + W'(1);
            end
        end
    end

    // state register
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign tick_o = st.tick;
endmodule : ctw_divider

// ---- core/ctw_rst_delay.sv ----
`include "ctw_defs.svh"

// holds release from the delayed reset pin until the delay count has run out
module ctw_rst_delay #(
    parameter int DLY_CYC = `CTW_DLY_RST_CYC
) (
    input  wire logic core_clk_i,
    input  wire logic resetn_i,
    input  wire logic delayed_reset_pin_n_i,
    input  wire logic tick_i,
    output logic      run_o
);
    localparam int W = $clog2(DLY_CYC + 1);

    typedef struct packed {
        logic [W-1:0] cnt;
        logic         run;
    } ctw_dly_s;

    ctw_dly_s st;
    ctw_dly_s next_st;

    // low pin restarts the count; high pin counts cycles with tick_i high
    always_comb begin
        next_st = st;
        if (!delayed_reset_pin_n_i) begin
            next_st.cnt = '0;
            next_st.run = 1'b0;
        end else if (!st.run && tick_i) begin
            if (st.cnt == W'(DLY_CYC - 1)) begin
                next_st.run = 1'b1;
            end else begin
                next_st.cnt = st.cnt + W'(1);
            end
        end
    end

    // state register
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            // immediate reset releases without the count
            st     <= '0;
            st.run <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign run_o = st.run;
endmodule : ctw_rst_delay

// ---- test/ctw_core_timer_asserts.sv ----
`include "ctw_defs.svh"

// port-level checks on the core timer
module ctw_core_timer_asserts
    import ctw_pkg::*;
#(
    parameter int DLY_CYC = 16,
    parameter int CNT_W   = 8
) (
    input  wire logic          core_clk_i,
    input  wire logic          resetn_i,
    input  ctw_pkg::ctw_addr_t addr_i,
    input  ctw_pkg::ctw_data_t wdata_i,
    input  wire logic          wr_i,
    input  wire logic          rd_i,
    input  ctw_pkg::ctw_data_t rdata_o,
    input  wire logic          timer_irq_o,
    input  wire logic          wdog_reset_o,
    input  wire logic          cpu_run_o,
    input  wire logic          cpu_clk_en_o
);
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!resetn_i);

    logic [1:0] sh_ie;
    logic [1:0] sh_rate;
    logic       sh_wddis;

    // shadow of the writable control fields, set to their reset values by either reset
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i || wdog_reset_o) begin
            sh_ie    <= 2'h0;
            sh_rate  <= 2'h3;
            sh_wddis <= 1'b1;
        end else begin
            if (wr_i && addr_i == `CTW_ADDR_TCS) begin
                sh_ie   <= wdata_i[5:4];
                sh_rate <= wdata_i[1:0];
            end
            if (wr_i && addr_i == `CTW_ADDR_WDC) begin
                sh_wddis <= wdata_i[0];
            end
        end
    end

    a_clear_bits_zero: assert property (
        rd_i && addr_i == `CTW_ADDR_TCS |=> rdata_o[3:2] == 2'h0)
        else $error("clear bits read nonzero");
    a_tcs_readback: assert property (
        rd_i && addr_i == `CTW_ADDR_TCS |=> rdata_o[5:4] == sh_ie && rdata_o[1:0] == sh_rate)
        else $error("control fields read wrong");
    a_wdc_readback: assert property (
        rd_i && addr_i == `CTW_ADDR_WDC |=> rdata_o[0] == sh_wddis)
        else $error("watchdog control reads wrong");
    a_wdog_disabled: assert property (sh_wddis |-> !wdog_reset_o)
        else $error("watchdog fired while disabled");
    a_wdog_resets: assert property (wdog_reset_o |-> ##[1:2] !cpu_run_o)
        else $error("watchdog did not reset the block");
    a_irq_enable: assert property (
        sh_ie == 2'h0 && $past(sh_ie) == 2'h0 |-> !timer_irq_o)
        else $error("request without enable");
    a_stop_halts: assert property (
        wr_i && addr_i == `CTW_ADDR_PSR && wdata_i == `CTW_PSR_CMD_STOP |-> ##[1:3] !cpu_clk_en_o)
        else $error("stop did not halt clock");
    a_idle_halts: assert property (
        wr_i && addr_i == `CTW_ADDR_PSR && wdata_i == `CTW_PSR_CMD_IDLE |-> ##[1:3] !cpu_clk_en_o)
        else $error("idle did not halt clock");
    a_clk_needs_run: assert property (cpu_clk_en_o |-> cpu_run_o)
        else $error("clock enabled before delay done");
endmodule : ctw_core_timer_asserts

// ---- test/ctw_cpu_model.sv ----
`include "ctw_defs.svh"

// processor side of the register port
module ctw_cpu_model
    import ctw_pkg::*;
(
    input  wire logic          core_clk_i,
    output ctw_pkg::ctw_addr_t addr_o,
    output ctw_pkg::ctw_data_t wdata_o,
    output logic               wr_o,
    output logic               rd_o,
    input  ctw_pkg::ctw_data_t rdata_i
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle bus at time zero
    initial begin
        addr_o  = 16'h0000;
        wdata_o = 8'h00;
        wr_o    = 1'b0;
        rd_o    = 1'b0;
    end

    // one write cycle; released lines show the inverse value
    task automatic wr(input ctw_addr_t a, input ctw_data_t d);
        @(posedge core_clk_i);
        addr_o  <= a;
        wdata_o <= d;
        wr_o    <= 1'b1;
        @(posedge core_clk_i);
        wr_o    <= 1'b0;
        addr_o  <= ~a;
        wdata_o <= ~d;
    endtask : wr

    // one read cycle, data taken in the cycle after the strobe
    task automatic rd(input ctw_addr_t a, output ctw_data_t d);
        @(posedge core_clk_i);
        addr_o <= a;
        rd_o   <= 1'b1;
        @(posedge core_clk_i);
        rd_o   <= 1'b0;
        addr_o <= ~a;
        #1;
        d = rdata_i;
    endtask : rd

    // watchdog service write
    task automatic service();
        wr(`CTW_ADDR_WDSVC, `CTW_WDSVC_DATA);
    endtask : service

    // control writes always follow a service, so rate changes are safe
    task automatic set_tcs(input ctw_data_t d);
        service();
        wr(`CTW_ADDR_TCS, d);
    endtask : set_tcs
endmodule : ctw_cpu_model

// ---- test/ctw_core_timer_tb.sv ----
`include "ctw_defs.svh"

module ctw_core_timer_tb;
    import ctw_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int DLY   = 16;
    localparam int LIMIT = 100000;

    logic        core_clk, resetn, dly_n, ext_irq, wr, rd, irq, wdog, run, clk_en;
    ctw_addr_t   addr;
    ctw_data_t   wdata, rdata, v, v2;
    int          err_count, total_checks, t0;
    int          cyc = 0;
    int unsigned seed = 46914;

    ctw_core_timer #(.DLY_CYC(DLY), .CNT_W(8)) ctw_core_timer_i (
        .core_clk_i(core_clk), .resetn_i(resetn), .delayed_reset_pin_n_i(dly_n),
        .ext_irq_i(ext_irq), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
        .rdata_o(rdata), .timer_irq_o(irq), .wdog_reset_o(wdog), .cpu_run_o(run),
        .cpu_clk_en_o(clk_en));
    ctw_cpu_model ctw_cpu_model_i (.core_clk_i(core_clk), .addr_o(addr), .wdata_o(wdata),
        .wr_o(wr), .rd_o(rd), .rdata_i(rdata));

    // 4 ns clock
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    // cycle count and hang guard
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            err_count++;
            final_report();
        end
    end

    function automatic ctw_data_t rnd8();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction : rnd8

    task automatic chk8(input ctw_data_t got, input ctw_data_t exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %0t read %h expected %h", $time, got, exp);
        end
    endtask : chk8

    task automatic chk1(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %0t level %b expected %b", $time, got, exp);
        end
    endtask : chk1

    task automatic rd_chk(input ctw_addr_t a, input ctw_data_t exp);
        ctw_data_t d;
        ctw_cpu_model_i.rd(a, d);
        chk8(d, exp);
    endtask : rd_chk

    // bounded wait for a level: 0 irq, 1 clock enable, 2 watchdog, 3 run
    task automatic wait_lvl(input int sel, input logic lvl, input int lim);
        int n;
        n = 0;
        while ((sel == 0 ? irq : sel == 1 ? clk_en : sel == 2 ? wdog : run) !== lvl
               && n < lim) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        chk1(n < lim, 1'b1);
    endtask : wait_lvl

    task automatic final_report();
        if (err_count == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : final_report

    // main sequence
    initial begin
        resetn  = 1'b0;
        dly_n   = 1'b1;
        ext_irq = 1'b0;
        repeat (3) @(posedge core_clk);
        resetn <= 1'b1;
        wait_lvl(3, 1'b1, 4);
        rd_chk(`CTW_ADDR_TCS, 8'h03);
        rd_chk(`CTW_ADDR_WDC, 8'h01);
        rd_chk(16'h0003, 8'h00);
        // delayed pin low drops run; after it rises run waits the full count
        @(posedge core_clk);
        dly_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
        chk1(run, 1'b0);
        @(posedge core_clk);
        dly_n <= 1'b1;
        repeat (DLY) @(posedge core_clk);
        #1;
        chk1(run, 1'b0);
        @(posedge core_clk);
        #1;
        chk1(run, 1'b1);
        // counter reads 64 clocks apart, a write between them
        ctw_cpu_model_i.rd(`CTW_ADDR_CNT, v);
        ctw_cpu_model_i.wr(`CTW_ADDR_CNT, rnd8());
        repeat (60) @(posedge core_clk);
        rd_chk(`CTW_ADDR_CNT, v + 8'h08);
        // every rate code with random enables and flag bits
        for (int i = 0; i < 4; i++) begin
            v = (rnd8() & 8'hf0) | 8'(i);
            ctw_cpu_model_i.set_tcs(v);
            rd_chk(`CTW_ADDR_TCS, v & 8'h33);
        end
        // idle ends on the enabled overflow request
        ctw_cpu_model_i.set_tcs(8'h20);
        ctw_cpu_model_i.wr(`CTW_ADDR_PSR, `CTW_PSR_CMD_IDLE);
        repeat (4) @(posedge core_clk);
        #1;
        chk1(clk_en, 1'b0);
        wait_lvl(1, 1'b1, 2100);
        wait_lvl(0, 1'b1, 4);
        rd_chk(`CTW_ADDR_TCS, 8'ha0);
        rd_chk(`CTW_ADDR_PSR, 8'h01);
        rd_chk(`CTW_ADDR_PSR, 8'h00);
        ctw_cpu_model_i.wr(`CTW_ADDR_TCS, 8'ha0);
        rd_chk(`CTW_ADDR_TCS, 8'ha0);
        ctw_cpu_model_i.wr(`CTW_ADDR_TCS, 8'h28);
        rd_chk(`CTW_ADDR_TCS, 8'h20);
        chk1(irq, 1'b0);
        // two periodic requests at the fastest rate
        ctw_cpu_model_i.wr(`CTW_ADDR_TCS, 8'h10);
        wait_lvl(0, 1'b1, 9000);
        t0 = cyc;
        rd_chk(`CTW_ADDR_TCS, 8'hd0);
        ctw_cpu_model_i.wr(`CTW_ADDR_TCS, 8'h14);
        wait_lvl(0, 1'b0, 8);
        wait_lvl(0, 1'b1, 8300);
        chk1(cyc - t0 == 8192, 1'b1);
        ctw_cpu_model_i.wr(`CTW_ADDR_TCS, 8'h04);
        // stop freezes the chain until the external interrupt
        ctw_cpu_model_i.rd(`CTW_ADDR_CNT, v);
        ctw_cpu_model_i.wr(`CTW_ADDR_PSR, `CTW_PSR_CMD_STOP);
        repeat (200) @(posedge core_clk);
        #1;
        chk1(clk_en, 1'b0);
        @(posedge core_clk);
        ext_irq <= 1'b1;
        wait_lvl(1, 1'b1, 16);
        @(posedge core_clk);
        ext_irq <= 1'b0;
        ctw_cpu_model_i.rd(`CTW_ADDR_CNT, v2);
        chk1(8'(v2 - v) < 8'h08, 1'b1);
        rd_chk(`CTW_ADDR_PSR, 8'h02);
        // watchdog runs out seven to eight periods after service
        ctw_cpu_model_i.service();
        ctw_cpu_model_i.wr(`CTW_ADDR_WDC, 8'h00);
        t0 = cyc;
        rd_chk(`CTW_ADDR_WDC, 8'h00);
        wait_lvl(2, 1'b1, 66000);
        chk1(cyc - t0 >= 57336 && cyc - t0 <= 65560, 1'b1);
        wait_lvl(3, 1'b0, 4);
        wait_lvl(3, 1'b1, 4);
        rd_chk(`CTW_ADDR_TCS, 8'h03);
        rd_chk(`CTW_ADDR_WDC, 8'h01);
        final_report();
    end
endmodule : ctw_core_timer_tb

bind ctw_core_timer ctw_core_timer_asserts #(.DLY_CYC(DLY_CYC), .CNT_W(CNT_W)) chk_i (
    .core_clk_i, .resetn_i, .addr_i, .wdata_i, .wr_i, .rd_i,
    .rdata_o, .timer_irq_o, .wdog_reset_o, .cpu_run_o, .cpu_clk_en_o);
